// ### hw/fsw_guard.sv
// Purpose: flash shield window guard with APB registers
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes: a request is judged one cycle after it is presented
//
// Register access over APB and the address map are this design's own decisions.
module fsw_guard (
    input  wire logic                        i_core_clk,   // core clock
    input  wire logic                        i_rst,        // sync reset
    input  wire logic                        psel,         // apb select
    input  wire logic                        penable,      // apb enable
    input  wire logic                        pwrite,       // apb direction
    input  wire logic [7:0]                  paddr,        // apb address
    input  wire logic [31:0]                 pwdata,       // apb write data
    output logic      [31:0]                 o_prdata,     // apb read data
    output logic                             o_pready,     // apb ready
    output logic                             o_pslverr,    // apb error
    input  wire logic                        i_req_valid,  // request strobe
    input  wire logic [1:0]                  i_req_cmd,    // request kind
    input  wire logic [fsw_pkg::BLK_W-1:0]   i_req_blk,    // target block
    output logic                             o_grant,      // request allowed pulse
    output logic                             o_deny,       // request refused pulse
    output logic                             o_self_mode,  // self-programming mode
    output logic                             o_boot_lock   // boot cluster 0 locked
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [fsw_pkg::BLK_W-1:0] wstart_r;
    logic [fsw_pkg::BLK_W-1:0] wend_r;
    logic                      self_r;
    logic                      boot_r;
    logic [7:0]                deny_cnt_r;
    logic                      wr_acc;
    logic                      rd_acc;
    logic                      known;

    // address decoding used twice
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == fsw_pkg::OFF_CTRL) || (a == fsw_pkg::OFF_WSTART) ||
               (a == fsw_pkg::OFF_WEND) || (a == fsw_pkg::OFF_STATUS);
    endfunction

    // window test, inclusive bounds
    function automatic logic in_window(input logic [fsw_pkg::BLK_W-1:0] b,
                                       input logic [fsw_pkg::BLK_W-1:0] s,
                                       input logic [fsw_pkg::BLK_W-1:0] e);
        return (b >= s) && (b <= e); // R10
    endfunction

    assign known  = is_mapped(paddr);
    assign wr_acc = psel && penable && o_pready && pwrite && known;
    assign rd_acc = psel && !penable && !pwrite;

    // window bounds, writable in either mode
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wstart_r <= fsw_pkg::WSTART_RST;
            wend_r   <= fsw_pkg::WEND_RST;
        end else if (wr_acc && paddr == fsw_pkg::OFF_WSTART) begin
            wstart_r <= pwdata[fsw_pkg::BLK_W-1:0]; // R5 R6
        end else if (wr_acc && paddr == fsw_pkg::OFF_WEND) begin
            wend_r <= pwdata[fsw_pkg::BLK_W-1:0]; // R5 R6
        end
    end

    // mode bit and sticky boot lock
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            self_r <= 1'b0;
            boot_r <= 1'b0;
        end else if (wr_acc && paddr == fsw_pkg::OFF_CTRL) begin
            self_r <= pwdata[fsw_pkg::CTRL_SELF_BIT];
            boot_r <= boot_r | pwdata[fsw_pkg::CTRL_BOOT_BIT]; // R9
        end
    end

    // apb answer: ready one cycle after setup, error on unmapped address
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= psel && !penable;
            o_pslverr <= psel && !penable && !known;
            if (rd_acc) begin
                case (paddr)
                    fsw_pkg::OFF_CTRL:   o_prdata <= {30'h0, boot_r, self_r};
                    fsw_pkg::OFF_WSTART: o_prdata <= {24'h0, wstart_r};
                    fsw_pkg::OFF_WEND:   o_prdata <= {24'h0, wend_r};
                    fsw_pkg::OFF_STATUS: o_prdata <= {24'h0, deny_cnt_r};
                    default:             o_prdata <= 32'h0000_0000;
                endcase
            end else begin
                o_prdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // request judge
    // ************************************************************
    logic is_op;
    logic in_boot;
    logic refuse;

    assign is_op   = (i_req_cmd == fsw_pkg::FSW_CMD_ERASE) || (i_req_cmd == fsw_pkg::FSW_CMD_WRITE);
    assign in_boot = i_req_blk < fsw_pkg::CLUSTER_BLKS; // R8
    assign refuse  = (boot_r && in_boot) || // R7
                     (self_r && !in_window(i_req_blk, wstart_r, wend_r)); // R1 R2 R3 R4

    // one-cycle verdict pulses
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_grant <= 1'b0;
            o_deny  <= 1'b0;
        end else begin
            o_grant <= i_req_valid && is_op && !refuse;
            o_deny  <= i_req_valid && is_op && refuse;
        end
    end

    // saturating refusal count, status view
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            deny_cnt_r <= 8'h00;
        end else if (o_deny && deny_cnt_r != 8'hFF) begin
            deny_cnt_r <= deny_cnt_r + 8'h01;
        end
    end

    // mirrored mode outputs
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_self_mode <= 1'b0;
            o_boot_lock <= 1'b0;
        end else begin
            o_self_mode <= self_r;
            o_boot_lock <= boot_r;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_self_out;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_req_valid && is_op && self_r && (i_req_blk < wstart_r || i_req_blk > wend_r)) |=> o_deny && !o_grant;
    endproperty
    a_self_out: assert property (p_self_out) else $error("out-of-window request granted in self mode"); // R1 R2

    property p_ext_any;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_req_valid && is_op && !self_r && !boot_r) |=> o_grant;
    endproperty
    a_ext_any: assert property (p_ext_any) else $error("external request refused"); // R3 R4

    property p_boot_prio;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_req_valid && is_op && boot_r && i_req_blk < fsw_pkg::CLUSTER_BLKS) |=> o_deny;
    endproperty
    a_boot_prio: assert property (p_boot_prio) else $error("boot cluster 0 rewrite allowed"); // R7 R8

    property p_boot_sticky;
        @(posedge i_core_clk) disable iff (i_rst)
        boot_r |=> boot_r;
    endproperty
    a_boot_sticky: assert property (p_boot_sticky) else $error("boot lock cleared"); // R9

    property p_in_window;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_req_valid && is_op && self_r && !boot_r && i_req_blk >= wstart_r && i_req_blk <= wend_r) |=> o_grant;
    endproperty
    a_in_window: assert property (p_in_window) else $error("in-window request refused"); // R10

    property p_wstart_load;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_acc && paddr == fsw_pkg::OFF_WSTART) |=> wstart_r == $past(pwdata[7:0]);
    endproperty
    a_wstart_load: assert property (p_wstart_load) else $error("window start not loaded"); // R5 R6

    property p_wend_load;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_acc && paddr == fsw_pkg::OFF_WEND) |=> wend_r == $past(pwdata[7:0]);
    endproperty
    a_wend_load: assert property (p_wend_load) else $error("window end not loaded"); // R5

    property p_exclusive;
        @(posedge i_core_clk) disable iff (i_rst)
        !(o_grant && o_deny);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("grant and refusal together"); // R1

    property p_no_idle_verdict;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_grant || o_deny) |-> $past(i_req_valid && is_op);
    endproperty
    a_no_idle_verdict: assert property (p_no_idle_verdict) else $error("verdict without request"); // R1 R3

    property p_ext_boot;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_req_valid && is_op && !self_r && boot_r && i_req_blk >= fsw_pkg::CLUSTER_BLKS) |=> o_grant;
    endproperty
    a_ext_boot: assert property (p_ext_boot) else $error("external request outside boot area refused"); // R3 R4

    property p_cnt_step;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_deny && deny_cnt_r != 8'hFF) |=> deny_cnt_r == $past(deny_cnt_r) + 8'h01;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("refusal not counted"); // R1

    property p_cnt_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        !o_deny |=> $stable(deny_cnt_r);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("refusal count moved without refusal"); // R1

    // ************************************************************
    // register and bus checks
    // ************************************************************
    property p_pready_setup;
        @(posedge i_core_clk) disable iff (i_rst)
        (psel && !penable) |=> o_pready;
    endproperty
    a_pready_setup: assert property (p_pready_setup) else $error("no ready after setup"); // R6

    property p_pready_pulse;
        @(posedge i_core_clk) disable iff (i_rst)
        o_pready |=> !o_pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("ready stood two cycles"); // R6

    property p_pslverr_unmapped;
        @(posedge i_core_clk) disable iff (i_rst)
        (psel && !penable && !known) |=> o_pslverr && o_pready;
    endproperty
    a_pslverr_unmapped: assert property (p_pslverr_unmapped) else $error("unmapped access not flagged"); // R6

    property p_pslverr_mapped;
        @(posedge i_core_clk) disable iff (i_rst)
        (psel && !penable && known) |=> !o_pslverr;
    endproperty
    a_pslverr_mapped: assert property (p_pslverr_mapped) else $error("mapped access flagged"); // R6

    property p_unmapped_ignored;
        @(posedge i_core_clk) disable iff (i_rst)
        (psel && penable && pwrite && !known) |=> $stable(wstart_r) && $stable(wend_r) && $stable(self_r);
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored) else $error("unmapped write landed"); // R5

    property p_rd_wstart;
        @(posedge i_core_clk) disable iff (i_rst)
        (psel && !penable && !pwrite && paddr == fsw_pkg::OFF_WSTART) |=> o_prdata == {24'h00_0000, wstart_r};
    endproperty
    a_rd_wstart: assert property (p_rd_wstart) else $error("window start read wrong"); // R5

    property p_rd_wend;
        @(posedge i_core_clk) disable iff (i_rst)
        (psel && !penable && !pwrite && paddr == fsw_pkg::OFF_WEND) |=> o_prdata == {24'h00_0000, wend_r};
    endproperty
    a_rd_wend: assert property (p_rd_wend) else $error("window end read wrong"); // R5

    property p_rd_ctrl;
        @(posedge i_core_clk) disable iff (i_rst)
        (psel && !penable && !pwrite && paddr == fsw_pkg::OFF_CTRL) |=> o_prdata == {30'h0000_0000, boot_r, self_r};
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong"); // R9

    property p_rd_status;
        @(posedge i_core_clk) disable iff (i_rst)
        (psel && !penable && !pwrite && paddr == fsw_pkg::OFF_STATUS) |=> o_prdata == {24'h00_0000, $past(deny_cnt_r)};
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong"); // R1

    property p_wstart_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        !(wr_acc && paddr == fsw_pkg::OFF_WSTART) |=> $stable(wstart_r);
    endproperty
    a_wstart_hold: assert property (p_wstart_hold) else $error("window start moved without write"); // R5

    property p_wend_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        !(wr_acc && paddr == fsw_pkg::OFF_WEND) |=> $stable(wend_r);
    endproperty
    a_wend_hold: assert property (p_wend_hold) else $error("window end moved without write"); // R5

    property p_self_load;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_acc && paddr == fsw_pkg::OFF_CTRL) |=> self_r == $past(pwdata[fsw_pkg::CTRL_SELF_BIT]);
    endproperty
    a_self_load: assert property (p_self_load) else $error("mode bit not loaded"); // R1 R3

    property p_boot_set;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_acc && paddr == fsw_pkg::OFF_CTRL && pwdata[fsw_pkg::CTRL_BOOT_BIT]) |=> boot_r;
    endproperty
    a_boot_set: assert property (p_boot_set) else $error("boot lock not set"); // R9

    property p_self_mirror;
        @(posedge i_core_clk) disable iff (i_rst)
        o_self_mode == $past(self_r);
    endproperty
    a_self_mirror: assert property (p_self_mirror) else $error("mode output does not follow mode bit"); // R1

    property p_boot_mirror;
        @(posedge i_core_clk) disable iff (i_rst)
        o_boot_lock == $past(boot_r);
    endproperty
    a_boot_mirror: assert property (p_boot_mirror) else $error("lock output does not follow lock bit"); // R9
endmodule

// ### hw/fsw_pkg.sv
// Purpose: constants for the flash shield window guard
// Assumes: blocks are 1 KB, so a 4 KB boot cluster spans four blocks
// Notes: register offsets are byte addresses on APB
//
// Summary of operation
// R1: self-programming refuses erase outside window
// R2: self-programming refuses write outside window
// R3: external programming allows erase anywhere except boot cluster 0 once boot protection is set
// R4: external programming allows write anywhere except boot cluster 0 once boot protection is set
// R5: window held as start and end block
// R6: window writable in either programming mode
// R7: boot cluster 0 protection overrides window
// R8: boot cluster is a 4 KB region
// R9: boot protection, once set, never clears; the code clears it on i_rst
// R10: inside means start <= block <= end
package fsw_pkg;
    localparam int unsigned BLK_W          = 8;
    localparam int unsigned CLUSTER_KB     = 4;
    localparam int unsigned BLOCK_KB       = 1;
    localparam logic [BLK_W-1:0] CLUSTER_BLKS = BLK_W'(CLUSTER_KB / BLOCK_KB);
    // register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_WSTART  = 8'h04;
    localparam logic [7:0] OFF_WEND    = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0C;
    // field positions
    localparam int unsigned CTRL_SELF_BIT = 0;
    localparam int unsigned CTRL_BOOT_BIT = 1;
    // reset values
    localparam logic [BLK_W-1:0] WSTART_RST = 8'h00;
    localparam logic [BLK_W-1:0] WEND_RST   = 8'hFF;
    // request kinds
    typedef enum logic [1:0] {
        FSW_CMD_NONE,
        FSW_CMD_ERASE,
        FSW_CMD_WRITE
    } fsw_cmd_t;
endpackage

// ### testbench/fsw_req_src.sv
// Purpose: request source model standing where firmware or a programmer sits
// Assumes: one request per call, verdict one cycle after the taking edge
// Notes: idle block and kind lines show inverted data, not stale values
module fsw_req_src (
    input  wire logic                      i_core_clk,  // core clock
    input  wire logic                      i_grant,     // allow pulse
    input  wire logic                      i_deny,      // refuse pulse
    output logic                           o_req_valid, // request strobe
    output logic [1:0]                     o_req_cmd,   // request kind
    output logic [fsw_pkg::BLK_W-1:0]      o_req_blk    // target block
);
    timeunit 1ns;
    timeprecision 1ns;
    // one strobe, then release with inverted lines and sample the verdict
    task automatic send(input logic [1:0] c, input logic [fsw_pkg::BLK_W-1:0] b, output logic g, output logic d);
        @(posedge i_core_clk);
        o_req_valid <= 1'b1;
        o_req_cmd   <= c;
        o_req_blk   <= b;
        @(posedge i_core_clk);
        o_req_valid <= 1'b0;
        o_req_cmd   <= ~c;
        o_req_blk   <= ~b;
        @(posedge i_core_clk);
        g = i_grant;
        d = i_deny;
    endtask
    initial begin
        o_req_valid = 1'b0;
        o_req_cmd   = 2'h0;
        o_req_blk   = 8'h00;
    end
endmodule

// ### testbench/fsw_guard_bench.sv
// Purpose: self-checking bench for the window guard
// Assumes: APB answers with one access cycle, verdicts one cycle late
// Notes: block size 1 KB, so boot cluster 0 is blocks 0 to 3
module fsw_guard_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_core_clk, i_rst, psel, penable, pwrite, o_pready, o_pslverr;
    logic        o_grant, o_deny, o_self_mode, o_boot_lock, req_valid;
    logic [1:0]  req_cmd;
    logic [7:0]  paddr, req_blk;
    logic [31:0] pwdata, o_prdata;
    int          miscompares = 0;
    int          checks = 0;
    fsw_guard u_fsw_guard (.i_core_clk(i_core_clk), .i_rst(i_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_req_valid(req_valid), .i_req_cmd(req_cmd), .i_req_blk(req_blk),
        .o_grant(o_grant), .o_deny(o_deny), .o_self_mode(o_self_mode), .o_boot_lock(o_boot_lock));
    fsw_req_src u_fsw_req_src (.i_core_clk(i_core_clk), .i_grant(o_grant), .i_deny(o_deny),
        .o_req_valid(req_valid), .o_req_cmd(req_cmd), .o_req_blk(req_blk));
    // ****************
    // helpers
    // ****************
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_data(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_verdict(input logic e, input logic g, input logic d);
        chk_data({30'h0, e, ~e}, {30'h0, g, d});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge i_core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge i_core_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        chk_data(32'h1, {31'h0, o_pready});
        rd = o_prdata;
        er = o_pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        chk_data({e[30:0], ee}, {rd[30:0], er});
    endtask
    task automatic req_chk(input logic [1:0] c, input logic [7:0] b, input logic e);
        logic g, d;
        u_fsw_req_src.send(c, b, g, d);
        chk_verdict(e, g, d);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        wr(8'h10, 32'h55);
        rd_chk(fsw_pkg::OFF_WSTART, 32'h0, 1'b0);
        rd_chk(fsw_pkg::OFF_WEND, 32'hFF, 1'b0);
        rd_chk(8'h10, 32'h0, 1'b1);
        chk_data(32'h0, {30'h0, o_self_mode, o_boot_lock});
    endtask
    task automatic t_external();
        logic g, d;
        wr(fsw_pkg::OFF_CTRL, 32'h0);
        wr(fsw_pkg::OFF_WSTART, 32'h4);
        wr(fsw_pkg::OFF_WEND, 32'h6);
        req_chk(2'h1, 8'h10, 1'b1);
        req_chk(2'h2, 8'h20, 1'b1);
        u_fsw_req_src.send(2'h3, 8'h20, g, d);
        chk_data(32'h0, {30'h0, g, d});
    endtask
    task automatic t_self();
        logic [7:0] blks [4] = '{8'h03, 8'h04, 8'h06, 8'h07};
        wr(fsw_pkg::OFF_CTRL, 32'h1);
        wr(fsw_pkg::OFF_WEND, 32'h6);
        chk_data(32'h1, {31'h0, o_self_mode});
        rd_chk(fsw_pkg::OFF_WSTART, 32'h4, 1'b0);
        for (int c = 1; c < 3; c++) begin
            foreach (blks[i]) req_chk(c[1:0], blks[i], blks[i] >= 8'h04 && blks[i] <= 8'h06);
        end
    endtask
    task automatic t_boot();
        wr(fsw_pkg::OFF_WSTART, 32'h0);
        wr(fsw_pkg::OFF_CTRL, 32'h3);
        rd_chk(fsw_pkg::OFF_CTRL, 32'h3, 1'b0);
        req_chk(2'h2, 8'h03, 1'b0);
        req_chk(2'h1, 8'h04, 1'b1);
        wr(fsw_pkg::OFF_CTRL, 32'h1);
        chk_data(32'h1, {31'h0, o_boot_lock});
        wr(fsw_pkg::OFF_CTRL, 32'h0);
        rd_chk(fsw_pkg::OFF_CTRL, 32'h2, 1'b0);
        req_chk(2'h1, 8'h00, 1'b0);
        req_chk(2'h1, 8'h04, 1'b1);
        wr(fsw_pkg::OFF_STATUS, 32'h0);
        rd_chk(fsw_pkg::OFF_STATUS, 32'h6, 1'b0);
    endtask
    // clock, reset, main sequence
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    initial begin
        i_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_reset();
        t_external();
        t_self();
        t_boot();
        close_out();
    end
    // watchdog cuts a hang short
    initial begin
        repeat (3000) @(posedge i_core_clk);
        miscompares++;
        close_out();
    end
endmodule
